//--- slnk_device.sv
// device end: eof char select, link status flags, channel and link control
//
// Operation
// [R01] eof select 0/1/2 picks K28.7/K28.1/K28.5
// [R02] eof char replaces repeated frame-end data only
// [R03] eof replacement only in 8b/10b modes
// [R04] software keeps select 0 for standard receiver
// [R05] generic 8b/10b receiver: software uses 1 or 2
// [R06] select changed only while link disabled
// [R07] software writes reserved eof bits as zero
// [R08] status bit 6 shows link up
// [R09] status bit 5 shows sync_n level
// [R10] status bit 4 sticky realign, write-1 clears
// [R11] status bit 3 set first sysref after enable
// [R12] status bit 2 shows serializer pll lock
// [R13] status bit 0 shows converter pll lock
// [R14] cal and link disabled before channel change
// [R15] live status bits ignore writes; zero keeps sticky
`timescale 1ns/1ps
`default_nettype none
`include "slnk_params.svh"

module slnk_device
(
  input  wire logic       mclk,                // 100 MHz block clock
  input  wire logic       nrst,                // async reset, active low
  slnk_reg_if.dev         bus,                 // register port
  input  wire logic       link_up,             // link state, same clock
  input  wire logic       sync_n,              // sync pin, asynchronous
  input  wire logic       sysref_realign,      // pulse: phase was shifted
  input  wire logic       sysref_event,        // pulse: sysref seen
  input  wire logic       serializer_pll_lock, // pll pin, asynchronous
  input  wire logic       converter_pll_lock,  // pll pin, asynchronous
  input  wire logic       mode_8b10b,          // output mode uses 8b/10b
  input  wire logic       tx_valid,            // lane byte valid
  input  wire logic [7:0] tx_data,             // lane byte from framer
  input  wire logic       tx_frame_end,        // byte is last of frame
  output logic            out_valid,           // encoder byte valid
  output logic      [7:0] out_data,            // byte to 8b/10b encoder
  output logic            out_is_k,            // byte is control char
  output logic            link_enable,         // link encoder enabled
  output logic            cal_enable,          // calibration enabled
  output logic      [7:0] channel_pair_enable  // channel pair enables
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pin_meta_q; // first stage, read by second stage only
  logic [2:0] pin_sync_q; // {sync_n, serializer lock, converter lock}

  // two flip-flops for each asynchronous pin
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {sync_n, serializer_pll_lock, converter_pll_lock};
      pin_sync_q <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_eof;    // write to eof select
  logic wr_status; // write to status flags
  logic wr_chen;   // write to channel enables
  logic wr_ctrl;   // write to link control

  assign wr_eof    = bus.wr && (bus.addr == `SLNK_EOF_OFS);
  assign wr_status = bus.wr && (bus.addr == `SLNK_STATUS_OFS);
  assign wr_chen   = bus.wr && (bus.addr == `SLNK_CHEN_OFS);
  assign wr_ctrl   = bus.wr && (bus.addr == `SLNK_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [1:0] eof_char_select_q; // end-of-frame char select
  logic [7:0] chen_q;            // channel pair enables
  logic [1:0] ctrl_q;            // {cal_enable, link_enable}

  // eof select; reserved upper bits are not stored and read zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      eof_char_select_q <= `SLNK_EOF_RST;
    else if (wr_eof)
      eof_char_select_q <= bus.wdata[1:0];
  end

  // channel pair enables, plain storage
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      chen_q <= `SLNK_CHEN_RST;
    else if (wr_chen)
      chen_q <= bus.wdata;
  end

  // link and calibration enables
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= `SLNK_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= bus.wdata[1:0];
  end

  assign link_enable         = ctrl_q[`SLNK_CTRL_LINK_EN];
  assign cal_enable          = ctrl_q[`SLNK_CTRL_CAL_EN];
  assign channel_pair_enable = chen_q;

  ////////////////////////////////////////////////////////////////////////
  // sticky alignment flags

  logic realigned_q;    // phase shifted by sysref
  logic multiframe_a_q; // multiframe phase established
  logic align_armed_q;  // waiting for first sysref after enable
  logic link_en_dly_q;  // link enable one cycle ago

  // realign flag: hardware set wins over write-one clear
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      realigned_q <= 1'b0;
    else if (sysref_realign)
      realigned_q <= 1'b1; // see [R10]
    else if (wr_status && bus.wdata[`SLNK_ST_REALIGN])
      realigned_q <= 1'b0; // see [R15]
  end

  // arm on link enable rising, disarm on the first sysref
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_en_dly_q <= 1'b0;
      align_armed_q <= 1'b0;
    end
    else
    begin
      link_en_dly_q <= link_enable;
      if (link_enable && !link_en_dly_q)
        align_armed_q <= 1'b1;
      else if (sysref_event || !link_enable)
        align_armed_q <= 1'b0;
    end
  end

  // multiframe_a flag: first sysref after enable, set wins over clear
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      multiframe_a_q <= 1'b0;
    else if (sysref_event && align_armed_q)
      multiframe_a_q <= 1'b1; // see [R11]
    else if (wr_status && bus.wdata[`SLNK_ST_MULTIFRAME_A])
      multiframe_a_q <= 1'b0; // see [R15]
  end

  ////////////////////////////////////////////////////////////////////////
  // status word and read answer

  logic [7:0] status;  // live and sticky flags
  logic [7:0] rd_mux;  // selected read value

  // live bits follow their sources; writes never reach them
  always_comb
  begin
    status                      = 8'h00;
    status[`SLNK_ST_LINK_UP]    = link_up;        // see [R08] [R15]
    status[`SLNK_ST_SYNC]       = pin_sync_q[2];  // see [R09]
    status[`SLNK_ST_REALIGN]    = realigned_q;
    status[`SLNK_ST_MULTIFRAME_A]    = multiframe_a_q;
    status[`SLNK_ST_SPLL]       = pin_sync_q[1];  // see [R12]
    status[`SLNK_ST_CPLL]       = pin_sync_q[0];  // see [R13]
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    unique case (bus.addr)
      `SLNK_EOF_OFS:    rd_mux = {6'h00, eof_char_select_q};
      `SLNK_STATUS_OFS: rd_mux = status;
      `SLNK_CHEN_OFS:   rd_mux = chen_q;
      `SLNK_CTRL_OFS:   rd_mux = {6'h00, ctrl_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  // answer one cycle after the read strobe
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus.rvalid <= 1'b0;
      bus.rdata  <= 8'h00;
    end
    else
    begin
      bus.rvalid <= bus.rd;
      if (bus.rd)
        bus.rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // end-of-frame character insertion

  logic [7:0] eof_code;    // selected control char byte
  logic       eof_allowed; // select names a usable char
  logic [7:0] last_end_q;  // frame-end byte of previous frame
  logic       have_end_q;  // last_end_q holds a real byte
  logic       replace;     // substitute this byte

  // select decode; reserved code disables replacement
  always_comb
  begin
    eof_allowed = 1'b1;
    unique case (slnk_pkg::slnk_eof_sel_t'(eof_char_select_q))
      slnk_pkg::SLNK_EOF_K28_7: eof_code = `SLNK_K28_7; // see [R01]
      slnk_pkg::SLNK_EOF_K28_1: eof_code = `SLNK_K28_1; // see [R01]
      slnk_pkg::SLNK_EOF_K28_5: eof_code = `SLNK_K28_5; // see [R01]
      slnk_pkg::SLNK_EOF_RSVD:
      begin
        eof_code    = `SLNK_K28_7;
        eof_allowed = 1'b0;
      end
    endcase
  end

  // only a frame end that repeats the previous one is replaced
  assign replace = tx_valid && tx_frame_end && have_end_q &&
                   (tx_data == last_end_q) && eof_allowed &&
                   mode_8b10b && link_enable; // see [R02] [R03]

  // remember raw frame-end data for the next comparison
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_end_q <= 8'h00;
      have_end_q <= 1'b0;
    end
    else if (!link_enable)
      have_end_q <= 1'b0;
    else if (tx_valid && tx_frame_end)
    begin
      last_end_q <= tx_data;
      have_end_q <= 1'b1;
    end
  end

  // registered byte to the encoder
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_is_k  <= 1'b0;
    end
    else
    begin
      out_valid <= tx_valid;
      out_data  <= replace ? eof_code : tx_data;
      out_is_k  <= replace;
    end
  end

endmodule : slnk_device

`default_nettype wire

//--- slnk_params.svh
// offsets, field positions, reset values and codes of the serial link regs
`ifndef SLNK_PARAMS_SVH
`define SLNK_PARAMS_SVH

// register offsets on the serial register port
`define SLNK_EOF_OFS      12'h207
`define SLNK_STATUS_OFS   12'h208
`define SLNK_CHEN_OFS     12'h209
`define SLNK_CTRL_OFS     12'h20a

// reset values
`define SLNK_EOF_RST      2'h0
`define SLNK_CHEN_RST     8'h03
`define SLNK_CTRL_RST     2'h0

// status field positions
`define SLNK_ST_LINK_UP   6
`define SLNK_ST_SYNC      5
`define SLNK_ST_REALIGN   4
`define SLNK_ST_MULTIFRAME_A   3
`define SLNK_ST_SPLL      2
`define SLNK_ST_CPLL      0

// control field positions
`define SLNK_CTRL_LINK_EN 0
`define SLNK_CTRL_CAL_EN  1

// encoded byte of each end-of-frame control character
`define SLNK_K28_7        8'hfc
`define SLNK_K28_1        8'h3c
`define SLNK_K28_5        8'hbc

`endif

//--- slnk_pkg.sv
// types of the serial link register block: eof select codes for the device end, sequencer states for the host end
`default_nettype none

package slnk_pkg;

  // end-of-frame character select codes
  typedef enum logic [1:0] {
    SLNK_EOF_K28_7,
    SLNK_EOF_K28_1,
    SLNK_EOF_K28_5,
    SLNK_EOF_RSVD
  } slnk_eof_sel_t;

  // host command sequencer states
  typedef enum logic [1:0] {
    SLNK_H_IDLE,
    SLNK_H_RD_WAIT,
    SLNK_H_RESP
  } slnk_host_state_t;

endpackage : slnk_pkg

`default_nettype wire

//--- slnk_reg_if.sv
// register port between the link device and its controlling host
`timescale 1ns/1ps
`default_nettype none

interface slnk_reg_if;
  logic        wr;     // write strobe, one cycle
  logic        rd;     // read strobe, one cycle
  logic [11:0] addr;   // register offset
  logic [7:0]  wdata;  // write data
  logic [7:0]  rdata;  // read data, valid with rvalid
  logic        rvalid; // read answer pulse

  // device end answers
  modport dev (input wr, input rd, input addr, input wdata,
               output rdata, output rvalid);
  // host end issues
  modport host (output wr, output rd, output addr, output wdata,
                input rdata, input rvalid);
endinterface : slnk_reg_if

`default_nettype wire

//--- slnk_host.sv
// host end: issues register commands and guards the programming order
`timescale 1ns/1ps
`default_nettype none
`include "slnk_params.svh"

module slnk_host
#(
  parameter bit STD_RX = 1'b1 // receiver is standard compliant
)
(
  input  wire logic        mclk,       // 100 MHz clock
  input  wire logic        nrst,       // async reset, active low
  slnk_reg_if.host         bus,        // register port
  input  wire logic        cmd_valid,  // command request
  input  wire logic        cmd_write,  // 1 write, 0 read
  input  wire logic [11:0] cmd_addr,   // register offset
  input  wire logic [7:0]  cmd_wdata,  // write data
  output logic             cmd_ready,  // command can be taken
  output logic             resp_valid, // command finished pulse
  output logic             resp_refused, // command was not issued
  output logic      [7:0]  resp_rdata  // read result
);

  slnk_pkg::slnk_host_state_t state_q; // sequencer state
  logic [1:0] ctrl_shadow_q;           // last written link control
  logic       refuse;                  // command breaks order
  logic [7:0] wdata_fix;               // write data after masking
  logic       take;                    // command accepted this cycle

  ////////////////////////////////////////////////////////////////////////
  // command checks

  // refuse writes that break the programming order
  always_comb
  begin
    refuse    = 1'b0;
    wdata_fix = cmd_wdata;
    if (cmd_write && cmd_addr == `SLNK_EOF_OFS)
    begin
      wdata_fix = {6'h00, cmd_wdata[1:0]}; // see [R07]
      if (ctrl_shadow_q[`SLNK_CTRL_LINK_EN])
        refuse = 1'b1; // see [R06]
      else if (STD_RX && cmd_wdata[1:0] != 2'h0)
        refuse = 1'b1; // see [R04]
      else if (!STD_RX && (cmd_wdata[1:0] == 2'h0 ||
                           cmd_wdata[1:0] == 2'h3))
        refuse = 1'b1; // see [R05]
    end
    if (cmd_write && cmd_addr == `SLNK_CHEN_OFS && ctrl_shadow_q != 2'h0)
      refuse = 1'b1; // see [R14]
  end

  assign cmd_ready = (state_q == slnk_pkg::SLNK_H_IDLE);
  assign take      = cmd_ready && cmd_valid;

  ////////////////////////////////////////////////////////////////////////
  // sequencer and bus strobes

  // one command in flight; reads wait for the answer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q      <= slnk_pkg::SLNK_H_IDLE;
      bus.wr       <= 1'b0;
      bus.rd       <= 1'b0;
      bus.addr     <= 12'h000;
      bus.wdata    <= 8'h00;
      resp_valid   <= 1'b0;
      resp_refused <= 1'b0;
      resp_rdata   <= 8'h00;
    end
    else
    begin
      bus.wr     <= 1'b0;
      bus.rd     <= 1'b0;
      resp_valid <= 1'b0;
      unique case (state_q)
        slnk_pkg::SLNK_H_IDLE:
          if (take)
          begin
            bus.addr     <= cmd_addr;
            bus.wdata    <= wdata_fix;
            resp_refused <= refuse;
            if (refuse || cmd_write)
            begin
              bus.wr     <= !refuse;
              resp_valid <= 1'b1;
            end
            else
            begin
              bus.rd  <= 1'b1;
              state_q <= slnk_pkg::SLNK_H_RD_WAIT;
            end
          end
        slnk_pkg::SLNK_H_RD_WAIT:
          if (bus.rvalid)
          begin
            resp_rdata <= bus.rdata;
            state_q    <= slnk_pkg::SLNK_H_RESP;
          end
        slnk_pkg::SLNK_H_RESP:
        begin
          resp_valid <= 1'b1;
          state_q    <= slnk_pkg::SLNK_H_IDLE;
        end
        default:
          state_q <= slnk_pkg::SLNK_H_IDLE;
      endcase
    end
  end

  // shadow of link control follows accepted writes
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ctrl_shadow_q <= `SLNK_CTRL_RST;
    else if (take && cmd_write && !refuse && cmd_addr == `SLNK_CTRL_OFS)
      ctrl_shadow_q <= cmd_wdata[1:0];
  end

endmodule : slnk_host

`default_nettype wire

//--- slnk_properties.sv
// register port checker watching both ends of the serial link block
`timescale 1ns/1ps
`default_nettype none
`include "slnk_params.svh"

module slnk_properties
#(
  parameter bit STD_RX = 1'b1 // host serves a standard receiver
)
(
  input wire logic        mclk,   // block clock
  input wire logic        nrst,   // async reset, active low
  input wire logic        wr,     // write strobe
  input wire logic        rd,     // read strobe
  input wire logic [11:0] addr,   // register offset
  input wire logic [7:0]  wdata,  // write data
  input wire logic [7:0]  rdata,  // read data
  input wire logic        rvalid  // read answer
);
  logic [1:0]  ctrl_q;  // shadow of link and cal enables
  logic [1:0]  eof_q;   // shadow of eof select
  logic [11:0] raddr_q; // offset of the last read

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // shadows follow the writes seen on the port
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= 2'h0;
      eof_q  <= 2'h0;
    end
    else if (wr && addr == `SLNK_CTRL_OFS)
      ctrl_q <= wdata[1:0];
    else if (wr && addr == `SLNK_EOF_OFS)
      eof_q <= wdata[1:0];
  end

  // remember where the pending read points
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      raddr_q <= 12'h000;
    else if (rd)
      raddr_q <= addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (
    rd |=> (rvalid && !rd && !wr) ##1 (!rd && !wr) [*2])
    else $error("read answer or spacing wrong");
  a_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("read answer without read");
  a_eof_resv_zero: assert property (
    wr && addr == `SLNK_EOF_OFS |-> wdata[7:2] == 6'h00)
    else $error("eof reserved bits not zero");
  a_eof_code_legal: assert property (
    wr && addr == `SLNK_EOF_OFS |-> (STD_RX ? wdata[1:0] == 2'h0
                                     : wdata[1:0] inside {2'h1, 2'h2}))
    else $error("eof code wrong for receiver");
  a_eof_link_off: assert property (
    wr && addr == `SLNK_EOF_OFS |-> !ctrl_q[0])
    else $error("eof changed with link on");
  a_chen_quiet: assert property (
    wr && addr == `SLNK_CHEN_OFS |-> ctrl_q == 2'h0)
    else $error("channel change with enables on");
  a_eof_readback: assert property (
    rvalid && raddr_q == `SLNK_EOF_OFS |-> rdata == {6'h00, eof_q})
    else $error("eof readback wrong");
  a_status_resv: assert property (
    rvalid && raddr_q == `SLNK_STATUS_OFS |-> !rdata[7] && !rdata[1])
    else $error("status reserved bit set");

  c_eof_write: cover property (wr && addr == `SLNK_EOF_OFS);
  c_chen_write: cover property (wr && addr == `SLNK_CHEN_OFS);
  c_status_read: cover property (rd && addr == `SLNK_STATUS_OFS);
endmodule : slnk_properties

`default_nettype wire

//--- serial_link_status_and_eof_char_test.sv
// bench joining host and device ends across the register port
`timescale 1ns/1ps
`default_nettype none
`include "slnk_params.svh"

module serial_link_status_and_eof_char_test;
  logic        mclk, nrst;                 // clock, reset
  logic        link_up, sync_n, realign;   // live status inputs
  logic        sref, ser_lock, conv_lock;  // sysref pulse, pll pins
  logic        mode_8b10b, tx_valid, tx_fe; // lane byte controls
  logic [7:0]  tx_data, out_data, chen;    // lane byte, result, enables
  logic        out_valid, out_is_k;        // encoder byte flags
  logic        link_en, cal_en;            // control outputs
  logic        cmd_valid, cmd_write, cmd_ready, resp_valid, resp_ref;
  logic [11:0] cmd_addr;                   // command offset
  logic [7:0]  cmd_wdata, resp_rdata;      // command data
  int          fail_count, checked, cyc;   // tallies, cycle count
  // expected control char per select code
  logic [7:0]  eof_ch [3] = '{`SLNK_K28_7, `SLNK_K28_1, `SLNK_K28_5};

  slnk_reg_if bus ();
  slnk_device slnk_device_inst (.mclk(mclk), .nrst(nrst), .bus(bus),
    .link_up(link_up), .sync_n(sync_n), .sysref_realign(realign),
    .sysref_event(sref), .serializer_pll_lock(ser_lock),
    .converter_pll_lock(conv_lock), .mode_8b10b(mode_8b10b),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_frame_end(tx_fe),
    .out_valid(out_valid), .out_data(out_data), .out_is_k(out_is_k),
    .link_enable(link_en), .cal_enable(cal_en), .channel_pair_enable(chen));
  slnk_host #(.STD_RX(1'b0)) slnk_host_inst (.mclk(mclk), .nrst(nrst),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_refused(resp_ref),
    .resp_rdata(resp_rdata));
  slnk_properties #(.STD_RX(1'b0)) slnk_properties_inst (.mclk(mclk),
    .nrst(nrst), .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out;
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // byte comparison, flags zero extended
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp8

  // one host command, waits a bounded time for its answer
  task automatic cmd(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic r,
                     output logic [7:0] q);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // a write answer stands only on the edge that took the command
    for (n = 0; n < 8; n++)
    begin
      #1;
      if (resp_valid === 1'b1)
        break;
      @(posedge mclk);
    end
    cmp8({6'h0, cmd_ready, resp_valid}, 8'h03);
    r = resp_ref;
    q = resp_rdata;
  endtask : cmd

  // write and judge whether it was refused
  task automatic wr_chk(input logic [11:0] a, input logic [7:0] d,
                        input logic e);
    logic       r;
    logic [7:0] q;
    cmd(1'b1, a, d, r, q);
    // the device register takes the strobe one edge later
    @(posedge mclk);
    #1;
    cmp8({7'h0, r}, {7'h0, e});
  endtask : wr_chk

  // read and judge the value
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic       r;
    logic [7:0] q;
    cmd(1'b0, a, 8'h00, r, q);
    cmp8(q, e);
  endtask : rd_chk

  // one frame-end byte through the lane path
  task automatic tx_chk(input logic [7:0] d, input logic k,
                        input logic [7:0] e);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data  <= d;
    tx_fe    <= 1'b1;
    @(posedge mclk);
    tx_valid <= 1'b0;
    #1;
    cmp8({7'h0, out_valid}, 8'h01);
    cmp8({7'h0, out_is_k}, {7'h0, k});
    cmp8(out_data, e);
  endtask : tx_chk

  // one-cycle sysref pulse, event or realign
  task automatic pulse(input bit ev);
    @(posedge mclk);
    if (ev)
      sref <= 1'b1;
    else
      realign <= 1'b1;
    @(posedge mclk);
    sref    <= 1'b0;
    realign <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // reset values of the tables and the control outputs
  task automatic t_reset;
    cmp8(chen, 8'h03);
    cmp8({6'h0, cal_en, link_en}, 8'h00);
    rd_chk(`SLNK_EOF_OFS, 8'h00);
    rd_chk(`SLNK_CHEN_OFS, 8'h03);
    rd_chk(`SLNK_CTRL_OFS, 8'h00);
    rd_chk(12'h300, 8'h00);
  endtask : t_reset

  // live bits and the two sticky alignment bits
  task automatic t_status;
    @(posedge mclk);
    link_up <= 1'b1;
    sync_n  <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(`SLNK_STATUS_OFS, 8'h64);
    @(posedge mclk);
    link_up   <= 1'b0;
    sync_n    <= 1'b0;
    conv_lock <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(`SLNK_STATUS_OFS, 8'h05);
    pulse(1'b0);
    rd_chk(`SLNK_STATUS_OFS, 8'h15);
    wr_chk(`SLNK_STATUS_OFS, 8'h00, 1'b0);
    rd_chk(`SLNK_STATUS_OFS, 8'h15);
    wr_chk(`SLNK_STATUS_OFS, 8'hf7, 1'b0);
    rd_chk(`SLNK_STATUS_OFS, 8'h05);
    pulse(1'b1);
    rd_chk(`SLNK_STATUS_OFS, 8'h05);
    wr_chk(`SLNK_CTRL_OFS, 8'h01, 1'b0);
    pulse(1'b1);
    rd_chk(`SLNK_STATUS_OFS, 8'h0d);
    wr_chk(`SLNK_STATUS_OFS, 8'h08, 1'b0);
    rd_chk(`SLNK_STATUS_OFS, 8'h05);
  endtask : t_status

  // replacement of repeated frame-end bytes, select codes 0 to 2
  task automatic t_frames;
    int i;
    @(posedge mclk);
    mode_8b10b <= 1'b1;
    tx_chk(8'h55, 1'b0, 8'h55);
    tx_chk(8'h55, 1'b1, eof_ch[0]);
    tx_chk(8'h66, 1'b0, 8'h66);
    @(posedge mclk);
    mode_8b10b <= 1'b0;
    tx_chk(8'h66, 1'b0, 8'h66);
    @(posedge mclk);
    mode_8b10b <= 1'b1;
    for (i = 1; i < 3; i++)
    begin
      wr_chk(`SLNK_CTRL_OFS, 8'h00, 1'b0);
      wr_chk(`SLNK_EOF_OFS, 8'(i), 1'b0);
      wr_chk(`SLNK_CTRL_OFS, 8'h01, 1'b0);
      tx_chk(8'(8'h10 + i), 1'b0, 8'(8'h10 + i));
      tx_chk(8'(8'h10 + i), 1'b1, eof_ch[i]);
    end
  endtask : t_frames

  // programming order guarded by the host
  task automatic t_refuse;
    cmp8({7'h0, link_en}, 8'h01);
    wr_chk(`SLNK_EOF_OFS, 8'h01, 1'b1);
    wr_chk(`SLNK_CHEN_OFS, 8'h01, 1'b1);
    wr_chk(`SLNK_CTRL_OFS, 8'h00, 1'b0);
    wr_chk(`SLNK_EOF_OFS, 8'h00, 1'b1);
    wr_chk(`SLNK_EOF_OFS, 8'h03, 1'b1);
    rd_chk(`SLNK_EOF_OFS, 8'h02);
    wr_chk(`SLNK_EOF_OFS, 8'hfd, 1'b0);
    rd_chk(`SLNK_EOF_OFS, 8'h01);
    wr_chk(`SLNK_CHEN_OFS, 8'h01, 1'b0);
    cmp8(chen, 8'h01);
    wr_chk(`SLNK_CTRL_OFS, 8'h02, 1'b0);
    cmp8({6'h0, cal_en, link_en}, 8'h02);
    wr_chk(`SLNK_CHEN_OFS, 8'h03, 1'b1);
    rd_chk(`SLNK_CHEN_OFS, 8'h01);
  endtask : t_refuse

  ////////////////////////////////////////////////////////////////////////////
  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    {nrst, link_up, sync_n, realign, sref, conv_lock} = 6'h00;
    {ser_lock, mode_8b10b, tx_valid, tx_fe} = 4'h8;
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata, tx_data} = 30'h0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_status();
    t_frames();
    t_refuse();
    close_out();
  end
endmodule : serial_link_status_and_eof_char_test

`default_nettype wire
